// ---- cvl_pkg.sv ----
// Constants, types and register map for the conveyor level control block
// Functional notes
// [RL1] Analog setpoint spans min to max voltage
// [RL2] Pulsed mode alternates run and stop times
// [RL3] One sensor: on after passive for on-delay
// [RL4] One sensor: off after active for off-delay
// [RL5] Level change restarts running delay from zero
// [RL6] Conveyor runs only while enable is active
// [RL7] Two sensors: on when both low, delayed
// [RL8] Two sensors: off when both high, else hold
// [RL9] Mode selects off, one or two sensors
// [RL10] Nonzero timeout: on too long, error, stop
// [RL11] Timeout value zero disables on-time monitoring
// [RL12] Switch-off disabled: keep running, flag only
// [RL13] Air first, drive only after pre-time
// [RL14] Air stays on for post-time after stop
// [RL15] Air drives only outputs set to air
// [RL16] Per-input polarity applied before level logic
// [RL17] All timers advance on 1 ms tick
package cvl_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ   = 125_000_000;
	localparam int unsigned TICK_MS  = 1;
	localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_IOCFG    = 8'h04;
	localparam logic [7:0] OFS_ON_DLY   = 8'h08;
	localparam logic [7:0] OFS_OFF_DLY  = 8'h0C;
	localparam logic [7:0] OFS_TMO      = 8'h10;
	localparam logic [7:0] OFS_PRE      = 8'h14;
	localparam logic [7:0] OFS_POST     = 8'h18;
	localparam logic [7:0] OFS_PLS_ON   = 8'h1C;
	localparam logic [7:0] OFS_PLS_OFF  = 8'h20;
	localparam logic [7:0] OFS_VOLT     = 8'h24;
	localparam logic [7:0] OFS_SETPT    = 8'h28;
	localparam logic [7:0] OFS_STATUS   = 8'h2C;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h30;
	localparam logic [7:0] OFS_IRQ_CLR  = 8'h34;
	localparam logic [7:0] OFS_IRQ_EN   = 8'h38;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_DLY   = 16'h001E;
	localparam logic [15:0] RST_PLS   = 16'h0032;
	localparam logic [15:0] RST_TMO   = 16'h0000;
	localparam logic [11:0] RST_VMIN  = 12'h032;
	localparam logic [11:0] RST_VMAX  = 12'h0C8;
	localparam logic [11:0] RST_SETPT = 12'h0C8;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned VMAX_POS  = 16;
	localparam int unsigned IRQ_ON    = 0;
	localparam int unsigned IRQ_OFF   = 1;
	localparam int unsigned IRQ_TMO   = 2;
	localparam int unsigned IRQ_W     = 3;

	// ----------------------------------------------------------------
	// Enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		LVL_OFF = 2'h0,
		LVL_ONE = 2'h1,
		LVL_TWO = 2'h2,
		LVL_RSV = 2'h3
	} cvl_lvl_mode_t;

	typedef enum logic [1:0] {
		IN_NONE   = 2'h0,
		IN_SENS1  = 2'h1,
		IN_SENS2  = 2'h2,
		IN_ENABLE = 2'h3
	} cvl_in_fn_t;

	typedef enum logic [1:0] {
		OUT_NONE    = 2'h0,
		OUT_AIR     = 2'h1,
		OUT_TIMEOUT = 2'h2,
		OUT_RUNNING = 2'h3
	} cvl_out_fn_t;

	// Control register layout, high bits first
	typedef struct packed {
		logic          analog_sel;
		logic          pulsed_en;
		logic          run_key;
		logic          tmo_stop;
		cvl_lvl_mode_t mode;
	} cvl_ctrl_t;

	localparam cvl_ctrl_t RST_CTRL = '{analog_sel: 1'b0, pulsed_en: 1'b0,
		run_key: 1'b0, tmo_stop: 1'b1, mode: LVL_OFF};

	// Observed block state, read back through the status register
	typedef struct packed {
		logic sens2;
		logic sens1;
		logic enable;
		logic tmo_err;
		logic air;
		logic drive;
	} cvl_stat_t;

endpackage

// ---- cvl_sync.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module cvl_sync #(
	parameter int unsigned W = 4
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// Data
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	logic [W-1:0] meta_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= '0;
			q_o    <= '0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end

endmodule

// ---- cvl_level_ctrl.sv ----
// Conveyor level control with sorting air, pulsing and Wishbone registers
//
// Implementation choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module cvl_level_ctrl #(
	parameter int unsigned NUM_IN   = 4,
	parameter int unsigned NUM_OUT  = 2,
	parameter int unsigned TICK_CYC = cvl_pkg::TICK_CYC
) (
	// Clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// Wishbone slave
	input  wire logic               cyc_i,
	input  wire logic               stb_i,
	input  wire logic               we_i,
	input  wire logic [7:0]         adr_i,
	input  wire logic [3:0]         sel_i,
	input  wire logic [31:0]        dat_i,
	output logic      [31:0]        dat_o,
	output logic                    ack_o,
	// Field pins
	input  wire logic [NUM_IN-1:0]  in_i,
	input  wire logic [7:0]         analog_i,
	output logic      [NUM_OUT-1:0] out_o,
	output logic                    drive_o,
	output logic      [11:0]        volt_o,
	output logic                    irq_o
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	cvl_pkg::cvl_ctrl_t       ctrl_q;
	logic [2*NUM_IN-1:0]      in_fn_q;
	logic [NUM_IN-1:0]        in_inv_q;
	logic [2*NUM_OUT-1:0]     out_fn_q;
	logic [15:0]              on_dly_q;
	logic [15:0]              off_dly_q;
	logic [15:0]              tmo_q;
	logic [15:0]              pre_q;
	logic [15:0]              post_q;
	logic [15:0]              pls_on_q;
	logic [15:0]              pls_off_q;
	logic [11:0]              vmin_q;
	logic [11:0]              vmax_q;
	logic [11:0]              setpt_q;
	logic [cvl_pkg::IRQ_W-1:0] irq_stat_q;
	logic [cvl_pkg::IRQ_W-1:0] irq_en_q;

	logic                     acc;
	logic                     wr;
	logic [NUM_IN-1:0]        in_sync;
	logic [NUM_IN-1:0]        in_act;
	logic                     sens1;
	logic                     sens2;
	logic                     en_in;
	logic                     enable;
	cvl_pkg::cvl_stat_t       stat;

	// Byte lane merge for writes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	// One tick past the limit: the first tick may come at once
	function automatic logic done(input logic [15:0] cnt,
		input logic [15:0] lim);
		return (lim == 16'h0000) || (cnt > lim);
	endfunction

	assign acc = cyc_i && stb_i && !ack_o;
	assign wr  = acc && we_i;

	// ----------------------------------------------------------------
	// Input conditioning
	// ----------------------------------------------------------------
	cvl_sync #(
		.W(NUM_IN)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i  (in_i),
		.q_o  (in_sync)
	);

	assign in_act = in_sync ^ in_inv_q; // [RL16]

	always_comb begin
		sens1 = 1'b0;
		sens2 = 1'b0;
		en_in = 1'b0;
		for (int i = 0; i < NUM_IN; i++) begin
			unique case (cvl_pkg::cvl_in_fn_t'(in_fn_q[2*i +: 2]))
				cvl_pkg::IN_SENS1:  sens1 = sens1 | in_act[i];
				cvl_pkg::IN_SENS2:  sens2 = sens2 | in_act[i];
				cvl_pkg::IN_ENABLE: en_in = en_in | in_act[i];
				cvl_pkg::IN_NONE:   ;
			endcase
		end
	end

	assign enable = ctrl_q.run_key | en_in; // [RL6]

	// ----------------------------------------------------------------
	// Millisecond tick
	// ----------------------------------------------------------------
	localparam int unsigned TW = $clog2(TICK_CYC + 1);
	logic [TW-1:0] div_q;
	logic          tick_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end else if (div_q == TW'(TICK_CYC - 1)) begin
			div_q  <= '0;
			tick_q <= 1'b1; // [RL17]
		end else begin
			div_q  <= div_q + 1'b1;
			tick_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Level evaluation
	// ----------------------------------------------------------------
	logic [1:0]  lvl_q;
	logic [15:0] dly_q;
	logic        lvl_on_q;
	logic        want_on;
	logic        want_off;

	always_comb begin
		want_on  = 1'b0;
		want_off = 1'b0;
		unique case (ctrl_q.mode)
			cvl_pkg::LVL_ONE: begin
				want_on  = !sens1; // [RL3]
				want_off = sens1;  // [RL4]
			end
			cvl_pkg::LVL_TWO: begin
				want_on  = !sens1 && !sens2; // [RL7]
				want_off = sens1 && sens2;   // [RL8]
			end
			default: ;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lvl_q    <= 2'b00;
			dly_q    <= '0;
			lvl_on_q <= 1'b0;
		end else begin
			lvl_q <= {sens2, sens1};
			if (ctrl_q.mode == cvl_pkg::LVL_OFF ||
				ctrl_q.mode == cvl_pkg::LVL_RSV) begin
				lvl_on_q <= 1'b1; // [RL9]
				dly_q    <= '0;
			end else if (lvl_q != {sens2, sens1}) begin
				dly_q <= '0; // [RL5]
			end else if ((!lvl_on_q && want_on) ||
				(lvl_on_q && want_off)) begin
				if (done(dly_q, lvl_on_q ? off_dly_q : on_dly_q)) begin
					lvl_on_q <= !lvl_on_q; // [RL3] [RL4] [RL7] [RL8]
					dly_q    <= '0;
				end else if (tick_q) begin
					dly_q <= dly_q + 1'b1;
				end
			end else begin
				dly_q <= '0;
			end
		end
	end

	// ----------------------------------------------------------------
	// On-time monitoring
	// ----------------------------------------------------------------
	logic [15:0] ontime_q;
	logic        tmo_err_q;
	logic        req;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ontime_q  <= '0;
			tmo_err_q <= 1'b0;
		end else if (!enable || !lvl_on_q) begin
			ontime_q  <= '0;
			tmo_err_q <= 1'b0;
		end else if (tmo_q == 16'h0000) begin
			ontime_q <= '0; // [RL11]
		end else if (done(ontime_q, tmo_q)) begin
			tmo_err_q <= 1'b1; // [RL10]
		end else if (tick_q) begin
			ontime_q <= ontime_q + 1'b1;
		end
	end

	// Error stops only when switch-off is selected
	assign req = enable && lvl_on_q &&
		!(tmo_err_q && ctrl_q.tmo_stop); // [RL6] [RL10] [RL12]

	// ----------------------------------------------------------------
	// Sorting air and drive sequence
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PRE,
		ST_RUN,
		ST_POST
	} cvl_seq_t;

	cvl_seq_t    seq_q;
	logic [15:0] seq_cnt_q;
	logic [15:0] pls_cnt_q;
	logic        pls_off_ph_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seq_q     <= ST_IDLE;
			seq_cnt_q <= '0;
		end else begin
			unique case (seq_q)
				ST_IDLE: begin
					seq_cnt_q <= '0;
					if (req) begin
						seq_q <= ST_PRE; // [RL13]
					end
				end
				ST_PRE: begin
					if (!req) begin
						seq_q     <= ST_POST;
						seq_cnt_q <= '0;
					end else if (done(seq_cnt_q, pre_q)) begin
						seq_q     <= ST_RUN; // [RL13]
						seq_cnt_q <= '0;
					end else if (tick_q) begin
						seq_cnt_q <= seq_cnt_q + 1'b1;
					end
				end
				ST_RUN: begin
					if (!req) begin
						seq_q     <= ST_POST; // [RL14]
						seq_cnt_q <= '0;
					end
				end
				ST_POST: begin
					if (req) begin
						seq_q     <= ST_PRE;
						seq_cnt_q <= '0;
					end else if (done(seq_cnt_q, post_q)) begin
						seq_q <= ST_IDLE; // [RL14]
					end else if (tick_q) begin
						seq_cnt_q <= seq_cnt_q + 1'b1;
					end
				end
			endcase
		end
	end

	// Pulse phase restarts with each run so the first slice is full
	always_ff @(posedge clk_i) begin
		if (rst_i || seq_q != ST_RUN || !ctrl_q.pulsed_en) begin
			pls_cnt_q    <= '0;
			pls_off_ph_q <= 1'b0;
		end else if (done(pls_cnt_q,
			pls_off_ph_q ? pls_off_q : pls_on_q)) begin
			pls_cnt_q    <= '0;
			pls_off_ph_q <= !pls_off_ph_q; // [RL2]
		end else if (tick_q) begin
			pls_cnt_q <= pls_cnt_q + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Output stage
	// ----------------------------------------------------------------
	logic        drive_d;
	logic        air_d;
	logic [11:0] target;
	logic [19:0] span;

	assign drive_d = (seq_q == ST_RUN) && !pls_off_ph_q; // [RL2] [RL13]
	assign air_d   = seq_q != ST_IDLE;                   // [RL13] [RL14]
	// Product kept at full width; a narrower span would clip high limits
	assign span    = 20'((vmax_q - vmin_q) * analog_i) / 20'd255;
	assign target  = ctrl_q.analog_sel ?
		12'(vmin_q + span[11:0]) : setpt_q; // [RL1]

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			drive_o <= 1'b0;
			volt_o  <= '0;
			out_o   <= '0;
		end else begin
			drive_o <= drive_d;
			volt_o  <= drive_d ? target : 12'h000;
			for (int i = 0; i < NUM_OUT; i++) begin
				unique case (cvl_pkg::cvl_out_fn_t'(out_fn_q[2*i +: 2]))
					cvl_pkg::OUT_AIR:     out_o[i] <= air_d; // [RL15]
					cvl_pkg::OUT_TIMEOUT: out_o[i] <= tmo_err_q; // [RL12]
					cvl_pkg::OUT_RUNNING: out_o[i] <= drive_d;
					cvl_pkg::OUT_NONE:    out_o[i] <= 1'b0;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	logic                      drive_pq;
	logic                      err_pq;
	logic [cvl_pkg::IRQ_W-1:0] ev;
	logic [cvl_pkg::IRQ_W-1:0] clr;

	always_comb begin
		ev                   = '0;
		ev[cvl_pkg::IRQ_ON]  = drive_d && !drive_pq;
		ev[cvl_pkg::IRQ_OFF] = !drive_d && drive_pq;
		ev[cvl_pkg::IRQ_TMO] = tmo_err_q && !err_pq;
		clr = '0;
		if (wr && adr_i == cvl_pkg::OFS_IRQ_CLR && sel_i[0]) begin
			clr = dat_i[cvl_pkg::IRQ_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			drive_pq   <= 1'b0;
			err_pq     <= 1'b0;
			irq_stat_q <= '0;
			irq_o      <= 1'b0;
		end else begin
			drive_pq   <= drive_d;
			err_pq     <= tmo_err_q;
			// Set wins over a clear in the same cycle
			irq_stat_q <= (irq_stat_q & ~clr) | ev;
			irq_o      <= |(((irq_stat_q & ~clr) | ev) & irq_en_q);
		end
	end

	// ----------------------------------------------------------------
	// Wishbone register file
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q    <= cvl_pkg::RST_CTRL;
			in_fn_q   <= '0;
			in_inv_q  <= '0;
			out_fn_q  <= '0;
			on_dly_q  <= cvl_pkg::RST_DLY;
			off_dly_q <= cvl_pkg::RST_DLY;
			tmo_q     <= cvl_pkg::RST_TMO;
			pre_q     <= cvl_pkg::RST_DLY;
			post_q    <= cvl_pkg::RST_DLY;
			pls_on_q  <= cvl_pkg::RST_PLS;
			pls_off_q <= cvl_pkg::RST_PLS;
			vmin_q    <= cvl_pkg::RST_VMIN;
			vmax_q    <= cvl_pkg::RST_VMAX;
			setpt_q   <= cvl_pkg::RST_SETPT;
			irq_en_q  <= '0;
		end else if (wr) begin
			unique case (adr_i)
				cvl_pkg::OFS_CTRL: ctrl_q <= cvl_pkg::cvl_ctrl_t'(
					merge(32'(ctrl_q), dat_i, sel_i));
				cvl_pkg::OFS_IOCFG: begin
					in_fn_q  <= (2*NUM_IN)'(merge(32'(in_fn_q),
						dat_i, sel_i));
					in_inv_q <= NUM_IN'(merge(32'(in_inv_q) << 8,
						dat_i, sel_i) >> 8);
					out_fn_q <= (2*NUM_OUT)'(merge(
						32'(out_fn_q) << 16, dat_i, sel_i) >> 16);
				end
				cvl_pkg::OFS_ON_DLY: on_dly_q <=
					16'(merge(32'(on_dly_q), dat_i, sel_i));
				cvl_pkg::OFS_OFF_DLY: off_dly_q <=
					16'(merge(32'(off_dly_q), dat_i, sel_i));
				cvl_pkg::OFS_TMO: tmo_q <=
					16'(merge(32'(tmo_q), dat_i, sel_i));
				cvl_pkg::OFS_PRE: pre_q <=
					16'(merge(32'(pre_q), dat_i, sel_i));
				cvl_pkg::OFS_POST: post_q <=
					16'(merge(32'(post_q), dat_i, sel_i));
				cvl_pkg::OFS_PLS_ON: pls_on_q <=
					16'(merge(32'(pls_on_q), dat_i, sel_i));
				cvl_pkg::OFS_PLS_OFF: pls_off_q <=
					16'(merge(32'(pls_off_q), dat_i, sel_i));
				cvl_pkg::OFS_VOLT: begin
					vmin_q <= 12'(merge(32'(vmin_q), dat_i, sel_i));
					vmax_q <= 12'(merge(32'(vmax_q) << cvl_pkg::VMAX_POS,
						dat_i, sel_i) >> cvl_pkg::VMAX_POS);
				end
				cvl_pkg::OFS_SETPT: setpt_q <=
					12'(merge(32'(setpt_q), dat_i, sel_i));
				cvl_pkg::OFS_IRQ_EN: irq_en_q <=
					(cvl_pkg::IRQ_W)'(merge(32'(irq_en_q), dat_i, sel_i));
				default: ;
			endcase
		end
	end

	assign stat = '{sens2: sens2, sens1: sens1, enable: enable,
		tmo_err: tmo_err_q, air: air_d, drive: drive_d};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= '0;
		end else begin
			ack_o <= acc;
			dat_o <= '0;
			if (acc && !we_i) begin
				unique case (adr_i)
					cvl_pkg::OFS_CTRL:     dat_o <= 32'(ctrl_q);
					cvl_pkg::OFS_IOCFG:    dat_o <= 32'(in_fn_q) |
						(32'(in_inv_q) << 8) | (32'(out_fn_q) << 16);
					cvl_pkg::OFS_ON_DLY:   dat_o <= 32'(on_dly_q);
					cvl_pkg::OFS_OFF_DLY:  dat_o <= 32'(off_dly_q);
					cvl_pkg::OFS_TMO:      dat_o <= 32'(tmo_q);
					cvl_pkg::OFS_PRE:      dat_o <= 32'(pre_q);
					cvl_pkg::OFS_POST:     dat_o <= 32'(post_q);
					cvl_pkg::OFS_PLS_ON:   dat_o <= 32'(pls_on_q);
					cvl_pkg::OFS_PLS_OFF:  dat_o <= 32'(pls_off_q);
					cvl_pkg::OFS_VOLT:     dat_o <= 32'(vmin_q) |
						(32'(vmax_q) << cvl_pkg::VMAX_POS);
					cvl_pkg::OFS_SETPT:    dat_o <= 32'(setpt_q);
					cvl_pkg::OFS_STATUS:   dat_o <= 32'(stat);
					cvl_pkg::OFS_IRQ_STAT: dat_o <= 32'(irq_stat_q);
					cvl_pkg::OFS_IRQ_EN:   dat_o <= 32'(irq_en_q);
					default:               dat_o <= '0;
				endcase
			end
		end
	end

endmodule

// ---- cvl_level_ctrl_properties.sv ----
// Port-level assertions for the conveyor level control block
`timescale 1ns/1ps
module cvl_level_ctrl_properties #(
	parameter int unsigned NUM_IN   = 4,
	parameter int unsigned NUM_OUT  = 2,
	parameter int unsigned TICK_CYC = cvl_pkg::TICK_CYC
) (
	// Clock and reset
	input wire logic               clk_i,
	input wire logic               rst_i,
	// Wishbone
	input wire logic               cyc_i,
	input wire logic               stb_i,
	input wire logic               we_i,
	input wire logic [7:0]         adr_i,
	input wire logic [31:0]        dat_i,
	input wire logic [31:0]        dat_o,
	input wire logic               ack_o,
	// Field pins
	input wire logic [NUM_OUT-1:0] out_o,
	input wire logic               drive_o,
	input wire logic [11:0]        volt_o,
	input wire logic               irq_o
);
	// ----------------------------------------------------------------
	// Shadow of the first output's function
	// ----------------------------------------------------------------
	logic [1:0] ofn_q;
	logic       air_sel;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ofn_q <= 2'h0;
		else if (cyc_i && stb_i && we_i && ack_o
			&& adr_i == cvl_pkg::OFS_IOCFG)
			ofn_q <= dat_i[17:16];
	end
	assign air_sel = ofn_q == cvl_pkg::OUT_AIR;
	default clocking dck @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	ack_once_a: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	ack_timely_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("bus request not answered next cycle");
	rdata_idle_a: assert property (!ack_o |-> dat_o == 32'h0000_0000)
		else $error("read data not zero outside ack");
	volt_off_a: assert property (!drive_o |-> volt_o == 12'h000)
		else $error("voltage present while drive off");
	rst_out_a: assert property ($fell(rst_i) |-> !drive_o && !irq_o)
		else $error("outputs active right after reset");
	air_cover_a: assert property (drive_o && air_sel |-> out_o[0])
		else $error("drive on without air");
	air_first_a: assert property
		($rose(drive_o) && air_sel |-> $past(out_o[0], 8))
		else $error("drive started before air pre-time");
	air_post_a: assert property
		($fell(drive_o) && air_sel |=> out_o[0] [*8])
		else $error("air dropped before post-time");
endmodule
bind cvl_level_ctrl cvl_level_ctrl_properties #(.NUM_IN(NUM_IN),
	.NUM_OUT(NUM_OUT), .TICK_CYC(TICK_CYC)) props (.clk_i(clk_i),
	.rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.out_o(out_o), .drive_o(drive_o), .volt_o(volt_o), .irq_o(irq_o));

// ---- cvl_field_model.sv ----
// Field side model: material sensors and enable contact
`timescale 1ns/1ps
module cvl_field_model (
	// Clock
	input  wire logic       clk_i,
	// Levels commanded by the bench
	input  wire logic       sens1_i,
	input  wire logic       sens2_i,
	input  wire logic       enable_i,
	input  wire logic       en_low_i,
	// Pins
	output logic      [3:0] pin_o
);
	// Unassigned pin toggles so an ignored input cannot pass by luck
	logic spare_q = 1'b0;
	always_ff @(posedge clk_i) begin
		spare_q <= !spare_q;
	end
	// Low-active contact wired inverted
	assign pin_o = {spare_q, enable_i ^ en_low_i, sens2_i, sens1_i};
endmodule

// ---- tb_cvl_level_ctrl.sv ----
// Self-checking testbench for the conveyor level control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	errors++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb_cvl_level_ctrl;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i  = 1'b0;
	logic [7:0]  adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0000_0000;
	logic [7:0]  analog = 8'hFF;
	logic        s1 = 1'b0;
	logic        s2 = 1'b0;
	logic        en = 1'b0;
	logic        en_low = 1'b0;
	logic [3:0]  pins_w;
	logic [31:0] dat_o;
	logic        ack_o;
	logic [1:0]  out_o;
	logic        drive_o;
	logic [11:0] volt_o;
	logic        irq_o;
	int          errors = 0;
	int          samples_checked = 0;
	int          wn;
	always #4 clk_i = !clk_i;
	// Short tick keeps millisecond delays to a few dozen cycles
	cvl_level_ctrl #(.TICK_CYC(10)) uut (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.in_i(pins_w), .analog_i(analog), .out_o(out_o),
		.drive_o(drive_o), .volt_o(volt_o), .irq_o(irq_o));
	cvl_field_model field (.clk_i(clk_i), .sens1_i(s1), .sens2_i(s2),
		.enable_i(en), .en_low_i(en_low), .pin_o(pins_w));
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1);
		`CHK("ack_lat", 2, n)
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e,
		input string nm);
		logic [31:0] q;
		wb(1'b0, a, 32'h0000_0000, q);
		`CHK(nm, e, q)
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic pins(input logic a, input logic b, input logic c);
		@(posedge clk_i);
		s1 <= a;
		s2 <= b;
		en <= c;
	endtask
	task automatic wdrv(input logic v, input int mx);
		wn = 0;
		while (drive_o !== v && wn < mx) begin
			@(posedge clk_i);
			wn++;
		end
		`CHK("drive", v, drive_o)
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		rdc(cvl_pkg::OFS_CTRL, 32'h0000_0004, "ctrl");
		rdc(cvl_pkg::OFS_OFF_DLY, 32'h0000_001E, "off_dly");
		rdc(cvl_pkg::OFS_TMO, 32'h0000_0000, "tmo");
		rdc(cvl_pkg::OFS_POST, 32'h0000_001E, "post");
		rdc(cvl_pkg::OFS_PLS_OFF, 32'h0000_0032, "pls_off");
		rdc(cvl_pkg::OFS_VOLT, 32'h00C8_0032, "volt");
		rdc(8'h3C, 32'h0000_0000, "unmapped");
		wr(cvl_pkg::OFS_STATUS, 32'hFFFF_FFFF);
		rdc(cvl_pkg::OFS_STATUS, 32'h0000_0000, "status_ro");
	endtask
	task automatic t_air();
		wr(cvl_pkg::OFS_IOCFG, 32'h0009_0039);
		wr(cvl_pkg::OFS_PRE, 32'h0000_0002);
		wr(cvl_pkg::OFS_POST, 32'h0000_0002);
		wr(cvl_pkg::OFS_CTRL, 32'h0000_000C);
		tick(12);
		`CHK("air_pre", 2'b01, out_o)
		`CHK("drv_pre", 1'b0, drive_o)
		wdrv(1'b1, 40);
		tick(2);
		`CHK("volt_set", 12'h0C8, volt_o)
		wr(cvl_pkg::OFS_CTRL, 32'h0000_0004);
		wdrv(1'b0, 20);
		tick(5);
		`CHK("air_post", 2'b01, out_o)
		tick(30);
		`CHK("air_off", 2'b00, out_o)
	endtask
	task automatic t_one();
		wr(cvl_pkg::OFS_IOCFG, 32'h0008_0039);
		wr(cvl_pkg::OFS_ON_DLY, 32'h0000_0003);
		wr(cvl_pkg::OFS_OFF_DLY, 32'h0000_0003);
		wr(cvl_pkg::OFS_PRE, 32'h0000_0000);
		pins(1'b1, 1'b0, 1'b1);
		wr(cvl_pkg::OFS_CTRL, 32'h0000_0005);
		tick(60);
		`CHK("one_full", 1'b0, drive_o)
		pins(1'b0, 1'b0, 1'b1);
		tick(25);
		pins(1'b1, 1'b0, 1'b1);
		tick(3);
		pins(1'b0, 1'b0, 1'b1);
		tick(25);
		`CHK("one_restart", 1'b0, drive_o)
		wdrv(1'b1, 60);
		`CHK("no_air_fn", 2'b00, out_o)
		pins(1'b1, 1'b0, 1'b1);
		tick(20);
		`CHK("off_wait", 1'b1, drive_o)
		wdrv(1'b0, 40);
		pins(1'b0, 1'b0, 1'b0);
		tick(80);
		`CHK("no_enable", 1'b0, drive_o)
	endtask
	task automatic t_two();
		wr(cvl_pkg::OFS_CTRL, 32'h0000_0006);
		pins(1'b0, 1'b0, 1'b1);
		wdrv(1'b1, 100);
		pins(1'b1, 1'b0, 1'b1);
		tick(80);
		`CHK("two_hold_on", 1'b1, drive_o)
		pins(1'b1, 1'b1, 1'b1);
		wdrv(1'b0, 60);
		pins(1'b0, 1'b1, 1'b1);
		tick(80);
		`CHK("two_hold_off", 1'b0, drive_o)
		pins(1'b0, 1'b0, 1'b0);
	endtask
	task automatic t_tmo();
		logic [31:0] q;
		wr(cvl_pkg::OFS_IOCFG, 32'h0009_0039);
		wr(cvl_pkg::OFS_PRE, 32'h0000_0001);
		wr(cvl_pkg::OFS_TMO, 32'h0000_0005);
		wr(cvl_pkg::OFS_IRQ_EN, 32'h0000_0004);
		wr(cvl_pkg::OFS_CTRL, 32'h0000_000C);
		wdrv(1'b1, 60);
		wdrv(1'b0, 100);
		wb(1'b0, cvl_pkg::OFS_STATUS, 32'h0000_0000, q);
		`CHK("tmo_err", 1'b1, q[2])
		`CHK("tmo_pin", 1'b1, out_o[1])
		`CHK("irq_set", 1'b1, irq_o)
		wr(cvl_pkg::OFS_IRQ_CLR, 32'h0000_0007);
		wr(cvl_pkg::OFS_IRQ_EN, 32'h0000_0000);
		tick(2);
		`CHK("irq_clr", 1'b0, irq_o)
		wr(cvl_pkg::OFS_CTRL, 32'h0000_0000);
		tick(5);
		wr(cvl_pkg::OFS_CTRL, 32'h0000_0008);
		wdrv(1'b1, 60);
		tick(100);
		`CHK("tmo_keep", 1'b1, drive_o)
		`CHK("tmo_msg", 1'b1, out_o[1])
		`CHK("irq_mask", 1'b0, irq_o)
		wr(cvl_pkg::OFS_IRQ_EN, 32'h0000_0004);
		tick(2);
		`CHK("irq_unmask", 1'b1, irq_o)
		wr(cvl_pkg::OFS_TMO, 32'h0000_0000);
		wr(cvl_pkg::OFS_CTRL, 32'h0000_0000);
		wr(cvl_pkg::OFS_IRQ_CLR, 32'h0000_0007);
		wdrv(1'b0, 20);
	endtask
	task automatic t_pulse();
		wr(cvl_pkg::OFS_PLS_ON, 32'h0000_0002);
		wr(cvl_pkg::OFS_PLS_OFF, 32'h0000_0002);
		wr(cvl_pkg::OFS_CTRL, 32'h0000_0018);
		wdrv(1'b1, 60);
		wdrv(1'b0, 40);
		`CHK("pulse_on", 1'b1, wn >= 15)
		wdrv(1'b1, 40);
		`CHK("pulse_off", 1'b1, wn >= 15)
		wr(cvl_pkg::OFS_CTRL, 32'h0000_0000);
		wdrv(1'b0, 40);
	endtask
	task automatic t_analog();
		wr(cvl_pkg::OFS_CTRL, 32'h0000_0028);
		wdrv(1'b1, 60);
		tick(2);
		`CHK("volt_max", 12'h0C8, volt_o)
		@(posedge clk_i) analog <= 8'h00;
		tick(3);
		`CHK("volt_min", 12'h032, volt_o)
		@(posedge clk_i) analog <= 8'h80;
		tick(3);
		`CHK("volt_mid", 12'h07D, volt_o)
		wr(cvl_pkg::OFS_CTRL, 32'h0000_0000);
		wdrv(1'b0, 20);
	endtask
	task automatic t_pol();
		@(posedge clk_i) en_low <= 1'b1;
		pins(1'b0, 1'b0, 1'b1);
		wr(cvl_pkg::OFS_CTRL, 32'h0000_0004);
		tick(60);
		`CHK("pol_high", 1'b0, drive_o)
		wr(cvl_pkg::OFS_IOCFG, 32'h0009_0439);
		wdrv(1'b1, 60);
		pins(1'b0, 1'b0, 1'b0);
		wdrv(1'b0, 20);
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#(8 * 20000);
		errors++;
		summarize();
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_air();
		t_one();
		t_two();
		t_tmo();
		t_pulse();
		t_analog();
		t_pol();
		summarize();
	end
endmodule
